// *** design/link_host.sv ***
// Function
// - start, eight data, even parity, two stops
// - idle frame is twelve high bits
// - sync 0x55 before each instruction
// - after store, wait for acknowledge character
// - host starts an exchange with sync only when SEND_SYNC_I is set
// - host rate stays under recommended maximum
// - host rate error within 1.5 percent
// - host sends two breaks back to back
// - break lasts 8192 peripheral clocks worth
// - after repeat, sync only before first
module link_host
    import link_host_pkg::*;
#(
    parameter int BIT_CYCLES = DEFAULT_BIT_CYCLES,
    parameter int BREAK_LEN = BREAK_CYCLES,
    parameter int ENABLE_WAIT_LEN = 1_750_000
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic LINE_I,
    output logic LINE_O,
    output logic LINE_OE_O,
    input wire logic ENABLE_REQ_I,
    input wire logic BREAK_REQ_I,
    input wire logic SEND_VALID_I,
    input wire logic [7:0] SEND_DATA_I,
    input wire logic SEND_SYNC_I,
    input wire logic EXPECT_I,
    output logic SEND_READY_O,
    output logic RX_VALID_O,
    output logic [7:0] RX_DATA_O,
    output logic RX_ERROR_O,
    output logic ACK_SEEN_O,
    output logic TIMEOUT_O,
    output logic BUSY_O
);
    bit_timer_if bt ();
    bit_timer u_timer (.clk_i(CLK_I), .rstn_i(RSTN_I), .bt(bt));

    logic [2:0] sync_line;
    logic line_s;
    logic [1:0] break_count;
    host_state_t state, next_state;
    logic [11:0] shift, next_shift;
    logic [3:0] bitn, next_bitn;
    logic [31:0] cnt, next_cnt;
    logic [7:0] rx_data, next_rx_data;
    logic rx_valid, next_rx_valid, rx_error, next_rx_error;
    logic ack_seen, next_ack_seen, timeout, next_timeout;
    logic pend_sync, next_pend_sync;
    logic [7:0] pend_data, next_pend_data;
    logic drive, next_drive, level, next_level;
    logic [1:0] next_break_count;
    logic [2:0] next_sync_line;
    logic next_line_s;

    // line passes three flops; a level counts once stages two and three agree
    always_comb begin
        next_sync_line = {sync_line[1:0], LINE_I};
        next_line_s = line_s;
        if (sync_line[1] == sync_line[2]) begin
            next_line_s = sync_line[2];
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sync_line <= 3'h7;
            line_s <= 1'b1;
        end else begin
            sync_line <= next_sync_line;
            line_s <= next_line_s;
        end
    end

    function automatic logic [11:0] make_frame(input logic [7:0] d);
        make_frame = {2'h3, even_parity(d), d, 1'b0};
    endfunction

    assign bt.cycles = 32'(BIT_CYCLES);
    assign bt.restart = (state == ST_IDLE) || (state == ST_RX_WAIT) || (state == ST_BREAK)
        || (state == ST_ENABLE_LOW) || (state == ST_ENABLE_WAIT);

    always_comb begin
        next_state = state;
        next_shift = shift;
        next_bitn = bitn;
        next_cnt = cnt;
        next_rx_data = rx_data;
        next_rx_valid = 1'b0;
        next_rx_error = 1'b0;
        next_ack_seen = 1'b0;
        next_timeout = 1'b0;
        next_pend_sync = pend_sync;
        next_pend_data = pend_data;
        next_drive = drive;
        next_level = level;
        next_break_count = break_count;
        case (state)
            ST_IDLE: begin
                next_drive = 1'b0;
                next_level = 1'b1;
                if (ENABLE_REQ_I) begin
                    next_state = ST_ENABLE_LOW;
                    next_drive = 1'b1;
                    next_level = 1'b0;
                    next_cnt = 32'h0;
                end else if (BREAK_REQ_I) begin
                    next_state = ST_BREAK;
                    next_drive = 1'b1;
                    next_level = 1'b0;
                    next_cnt = 32'h0;
                    next_break_count = 2'h2;
                end else if (SEND_VALID_I) begin
                    next_pend_data = SEND_DATA_I;
                    next_pend_sync = SEND_SYNC_I;
                    next_shift = SEND_SYNC_I ? make_frame(SYNC_VALUE)
                        : make_frame(SEND_DATA_I);
                    next_bitn = FRAME_BITS;
                    next_state = ST_TX;
                    next_drive = 1'b1;
                    next_level = 1'b0;
                end else if (EXPECT_I) begin
                    next_state = ST_RX_WAIT;
                    next_cnt = 32'h0;
                end
            end
            ST_ENABLE_LOW: begin
                next_cnt = cnt + 32'h1;
                if (cnt + 32'h1 >= 32'(ENABLE_LOW_CYCLES)) begin
                    next_drive = 1'b0;
                    next_state = ST_ENABLE_WAIT;
                    next_cnt = 32'h0;
                end
            end
            ST_ENABLE_WAIT: begin
                // device holds the line low until its clock runs
                next_cnt = cnt + 32'h1;
                if (line_s && cnt > 32'h4) begin
                    next_state = ST_IDLE;
                end else if (cnt + 32'h1 >= 32'(ENABLE_WAIT_LEN)) begin
                    next_timeout = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_BREAK: begin
                next_cnt = cnt + 32'h1;
                if (cnt + 32'h1 >= 32'(BREAK_LEN)) begin
                    next_cnt = 32'h0;
                    if (level == 1'b0) begin
                        next_level = 1'b1;
                        next_break_count = break_count - 2'h1;
                    end else if (break_count == 2'h0) begin
                        next_drive = 1'b0;
                        next_state = ST_IDLE;
                    end else begin
                        next_level = 1'b0;
                    end
                end
            end
            ST_TX: begin
                next_level = shift[0];
                if (bt.tick) begin
                    next_shift = {1'b1, shift[11:1]};
                    next_bitn = bitn - 4'h1;
                    next_level = shift[1];
                    if (bitn == 4'h1) begin
                        next_drive = 1'b0;
                        next_level = 1'b1;
                        if (pend_sync) begin
                            // the instruction byte follows its own sync
                            next_pend_sync = 1'b0;
                            next_shift = make_frame(pend_data);
                            next_bitn = FRAME_BITS;
                            next_drive = 1'b1;
                            next_level = 1'b0;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
            end
            ST_RX_WAIT: begin
                next_cnt = cnt + 32'h1;
                if (!line_s) begin
                    next_state = ST_RX;
                    next_bitn = 4'h0;
                end else if (cnt >= 32'(ACK_TIMEOUT_BITS * BIT_CYCLES)) begin
                    next_timeout = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_RX: begin
                if (bt.half) begin
                    next_shift = {line_s, shift[11:1]};
                    next_bitn = bitn + 4'h1;
                    if (bitn == 4'hb) begin
                        next_state = ST_RX_DONE;
                    end
                end
            end
            ST_RX_DONE: begin
                next_rx_data = shift[8:1];
                next_rx_valid = 1'b1;
                next_rx_error = shift[0] || !shift[10] || !shift[11]
                    || (even_parity(shift[8:1]) != shift[9]);
                next_ack_seen = (shift[8:1] == ACK_VALUE);
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state <= ST_IDLE;
            shift <= 12'hfff;
            bitn <= 4'h0;
            cnt <= 32'h0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_error <= 1'b0;
            ack_seen <= 1'b0;
            timeout <= 1'b0;
            pend_sync <= 1'b0;
            pend_data <= 8'h00;
            drive <= 1'b0;
            level <= 1'b1;
            break_count <= 2'h0;
        end else begin
            state <= next_state;
            shift <= next_shift;
            bitn <= next_bitn;
            cnt <= next_cnt;
            rx_data <= next_rx_data;
            rx_valid <= next_rx_valid;
            rx_error <= next_rx_error;
            ack_seen <= next_ack_seen;
            timeout <= next_timeout;
            pend_sync <= next_pend_sync;
            pend_data <= next_pend_data;
            drive <= next_drive;
            level <= next_level;
            break_count <= next_break_count;
        end
    end

    assign LINE_O = level;
    assign LINE_OE_O = drive;
    assign SEND_READY_O = (state == ST_IDLE) && !ENABLE_REQ_I && !BREAK_REQ_I;
    assign RX_VALID_O = rx_valid;
    assign RX_DATA_O = rx_data;
    assign RX_ERROR_O = rx_error;
    assign ACK_SEEN_O = ack_seen;
    assign TIMEOUT_O = timeout;
    assign BUSY_O = (state != ST_IDLE);
endmodule

// *** design/link_host_pkg.sv ***
package link_host_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 2;
    localparam int IDLE_BITS = 12;
    localparam int BREAK_BITS = 12;
    localparam logic [7:0] SYNC_VALUE = 8'h55;
    localparam logic [7:0] ACK_VALUE = 8'h40;
    localparam int DEFAULT_BAUD = 115_200;
    localparam int DEFAULT_BIT_CYCLES = (CLK_HZ + DEFAULT_BAUD - 1) / DEFAULT_BAUD;
    localparam int BREAK_TIME_US = 24_600;
    localparam int BREAK_CYCLES = BREAK_TIME_US * (CLK_HZ / 1_000_000);
    localparam int ENABLE_LOW_NS = 500;
    localparam int ENABLE_LOW_CYCLES = (ENABLE_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ACK_TIMEOUT_BITS = 64;
    localparam logic [3:0] FRAME_BITS = 4'hc;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ENABLE_LOW = 4'h1,
        ST_ENABLE_WAIT = 4'h2,
        ST_TX = 4'h3,
        ST_TX_GAP = 4'h4,
        ST_BREAK = 4'h5,
        ST_RX_WAIT = 4'h6,
        ST_RX = 4'h7,
        ST_RX_DONE = 4'h8
    } host_state_t;

    function automatic logic even_parity(input logic [7:0] d);
        even_parity = ^d;
    endfunction
endpackage

// *** design/bit_timer_if.sv ***
interface bit_timer_if;
    logic restart;
    logic [31:0] cycles;
    logic tick;
    logic half;
    modport ctrl (output restart, output cycles, input tick, input half);
    modport timer (input restart, input cycles, output tick, output half);
endinterface

// *** design/bit_timer.sv ***
module bit_timer (
    input wire logic clk_i,
    input wire logic rstn_i,
    bit_timer_if.timer bt
);
    logic [31:0] count;
    logic [31:0] next_count;

    always_comb begin
        next_count = count + 32'h1;
        if (bt.restart || next_count >= bt.cycles) begin
            next_count = 32'h0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count <= 32'h0;
        end else begin
            count <= next_count;
        end
    end

    assign bt.tick = !bt.restart && (count + 32'h1 >= bt.cycles);
    assign bt.half = !bt.restart && (count == (bt.cycles >> 1));
endmodule

// *** bench/link_host_checker.sv ***
module link_host_checker
    import link_host_pkg::*;
#(
    parameter int BIT_CYCLES = 12,
    parameter int BREAK_LEN = 200
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic LINE_O,
    input wire logic LINE_OE_O,
    input wire logic ENABLE_REQ_I,
    input wire logic BREAK_REQ_I,
    input wire logic SEND_VALID_I,
    input wire logic EXPECT_I,
    input wire logic SEND_READY_O,
    input wire logic BUSY_O,
    input wire logic RX_VALID_O,
    input wire logic [7:0] RX_DATA_O,
    input wire logic RX_ERROR_O,
    input wire logic ACK_SEEN_O,
    input wire logic TIMEOUT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RX_LIMIT = 900;
    int low_run;
    int high_run;
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            low_run <= 0;
            high_run <= 0;
        end else begin
            low_run <= (LINE_OE_O && !LINE_O) ? low_run + 1 : 0;
            high_run <= (LINE_OE_O && LINE_O) ? high_run + 1 : 0;
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    sequence s_idle_take;
        !BUSY_O && !ENABLE_REQ_I;
    endsequence
    sequence s_start_bit;
        LINE_OE_O && !LINE_O;
    endsequence
    chk_send_start: assert property (SEND_READY_O && SEND_VALID_I |=> s_start_bit)
        else $error("no start bit after send");
    chk_bit_width: assert property ($rose(LINE_O) && LINE_OE_O |->
        (low_run % BIT_CYCLES == 0 || low_run == BREAK_LEN))
        else $error("low run not whole bits");
    chk_stop_bits: assert property ($fell(LINE_OE_O) && $past(LINE_O) |->
        high_run >= 2 * BIT_CYCLES)
        else $error("stop bits too short");
    chk_break_start: assert property (s_idle_take ##0 BREAK_REQ_I |=> s_start_bit)
        else $error("break not started");
    chk_break_max: assert property (low_run <= BREAK_LEN)
        else $error("low held too long");
    chk_idle_quiet: assert property (!BUSY_O |-> !LINE_OE_O)
        else $error("line driven while idle");
    chk_ready_rule: assert property (SEND_READY_O |-> !BUSY_O && !BREAK_REQ_I)
        else $error("ready while busy");
    chk_rx_pulse: assert property (RX_VALID_O |=> !RX_VALID_O)
        else $error("rx valid not a pulse");
    chk_err_pulse: assert property (RX_ERROR_O |=> !RX_ERROR_O)
        else $error("rx error not a pulse");
    chk_ack_value: assert property (ACK_SEEN_O |-> RX_DATA_O == ACK_VALUE)
        else $error("ack flag on wrong byte");
    chk_rx_bound: assert property (s_idle_take ##0 (EXPECT_I && !SEND_VALID_I && !BREAK_REQ_I)
        |-> ##[1:RX_LIMIT] (RX_VALID_O || RX_ERROR_O || TIMEOUT_O))
        else $error("receive wait unbounded");
endmodule

bind link_host link_host_checker #(.BIT_CYCLES(BIT_CYCLES), .BREAK_LEN(BREAK_LEN)) u_chk (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .LINE_O(LINE_O), .LINE_OE_O(LINE_OE_O),
    .ENABLE_REQ_I(ENABLE_REQ_I), .BREAK_REQ_I(BREAK_REQ_I), .SEND_VALID_I(SEND_VALID_I),
    .EXPECT_I(EXPECT_I), .SEND_READY_O(SEND_READY_O), .BUSY_O(BUSY_O),
    .RX_VALID_O(RX_VALID_O), .RX_DATA_O(RX_DATA_O), .RX_ERROR_O(RX_ERROR_O),
    .ACK_SEEN_O(ACK_SEEN_O), .TIMEOUT_O(TIMEOUT_O));

// *** bench/dev_model.sv ***
module dev_model #(
    parameter int BIT_CYCLES = 12,
    parameter int GUARD_BITS = 2
) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o,
    output logic line_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];
    int n_bad = 0;
    int n_break = 0;
    logic enabled = 1'b0;
    logic parity_check_disable = 1'b0;
    logic in_error = 1'b0;
    int hold = 100;
    logic [11:0] f;
    task automatic send(input logic [7:0] d, input logic bad_par);
        logic [11:0] fr;
        fr = {2'b11, ^d ^ bad_par, d, 1'b0};
        // idle bits before turning the line around
        repeat (GUARD_BITS * BIT_CYCLES) @(posedge clk_i);
        for (int i = 0; i < 12; i++) begin
            #1 line_oe_o = 1'b1;
            line_o = fr[i];
            repeat (BIT_CYCLES) @(posedge clk_i);
        end
        #1 line_oe_o = 1'b0;
    endtask
    initial begin
        line_o = 1'b1;
        line_oe_o = 1'b0;
        forever begin
            @(posedge clk_i iff (line_i === 1'b0 && !line_oe_o));
            if (!enabled) begin
                // keep the line low until our clock is up
                #1 line_oe_o = 1'b1;
                line_o = 1'b0;
                repeat (hold) @(posedge clk_i);
                #1 line_oe_o = 1'b0;
                enabled = 1'b1;
            end else begin
                repeat (BIT_CYCLES / 2) @(posedge clk_i);
                for (int i = 0; i < 12; i++) begin
                    f[i] = line_i;
                    if (i < 11) repeat (BIT_CYCLES) @(posedge clk_i);
                end
                if (f == 12'h000) begin
                    n_break++;
                    in_error = 1'b0;
                    @(posedge clk_i iff line_i === 1'b1);
                end else begin
                    if (f[11:10] != 2'b11 || (!parity_check_disable && ^f[9:1])) begin
                        n_bad++;
                        in_error = 1'b1;
                    end
                    // a faulted link drops everything until a break
                    if (!in_error) rx_q.push_back(f[8:1]);
                end
            end
        end
    end
endmodule

// *** bench/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import link_host_pkg::*;
    localparam int BC = 12;
    typedef struct packed {logic [7:0] data; logic sync;} row_t;
    localparam row_t ROWS[5] = '{'{8'h00, 1'b1}, '{8'hff, 1'b0}, '{8'ha5, 1'b1},
        '{8'h01, 1'b0}, '{8'h80, 1'b1}};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic en_req = 1'b0;
    logic brk_req = 1'b0;
    logic send_valid = 1'b0;
    logic [7:0] send_data = 8'h00;
    logic send_sync = 1'b0;
    logic expect_rx = 1'b0;
    logic host_o, host_oe, dev_o, dev_oe, ready, rx_valid, rx_error, ack_seen, timeout, busy;
    logic [7:0] rx_data;
    wire line = (host_oe ? host_o : 1'b1) & (dev_oe ? dev_o : 1'b1);
    int n_errors = 0;
    int cmp_count = 0;
    always #4 clk = ~clk;
    link_host #(.BIT_CYCLES(BC), .BREAK_LEN(200), .ENABLE_WAIT_LEN(500)) u_link_host (
        .CLK_I(clk), .RSTN_I(rstn), .LINE_I(line), .LINE_O(host_o), .LINE_OE_O(host_oe),
        .ENABLE_REQ_I(en_req), .BREAK_REQ_I(brk_req), .SEND_VALID_I(send_valid),
        .SEND_DATA_I(send_data), .SEND_SYNC_I(send_sync), .EXPECT_I(expect_rx),
        .SEND_READY_O(ready), .RX_VALID_O(rx_valid), .RX_DATA_O(rx_data),
        .RX_ERROR_O(rx_error), .ACK_SEEN_O(ack_seen), .TIMEOUT_O(timeout), .BUSY_O(busy));
    dev_model #(.BIT_CYCLES(BC)) u_dev_model (.clk_i(clk), .line_i(line), .line_o(dev_o),
        .line_oe_o(dev_oe));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic wait_idle();
        int n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check("idle", 1, n < 3000);
    endtask
    task automatic wait_rx(output int n);
        n = 0;
        while (!(rx_valid === 1'b1 || rx_error === 1'b1 || timeout === 1'b1) && n < 1000) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic expect_byte(input logic [7:0] d, input logic bad, output int n);
        pulse(expect_rx);
        if (d != 8'h00) fork u_dev_model.send(d, bad); join_none
        wait_rx(n);
    endtask
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
    initial begin
        int n;
        repeat (12) @(negedge clk);
        check("reset oe", 0, host_oe);
        check("reset ready", 1, ready);
        rstn = 1'b1;
        pulse(en_req);
        wait_idle();
        check("enabled", 1, u_dev_model.enabled);
        foreach (ROWS[i]) begin
            send_data = ROWS[i].data;
            send_sync = ROWS[i].sync;
            pulse(send_valid);
            wait_idle();
            if (ROWS[i].sync) check("sync", SYNC_VALUE, u_dev_model.rx_q.pop_front());
            check("data", ROWS[i].data, u_dev_model.rx_q.pop_front());
        end
        check("frame faults", 0, u_dev_model.n_bad);
        expect_byte(ACK_VALUE, 1'b0, n);
        check("rx data", ACK_VALUE, rx_data);
        check("ack", 1, ack_seen);
        check("rx valid", 1, rx_valid);
        expect_byte(8'h12, 1'b1, n);
        check("rx error", 1, rx_error);
        check("bad rx data", 8'h12, rx_data);
        check("no ack", 0, ack_seen);
        expect_byte(8'h00, 1'b0, n);
        check("timeout", 1, timeout);
        check("timeout late", 1, n >= 60 * BC);
        pulse(brk_req);
        pulse(send_valid); // ignored while busy
        wait_idle();
        check("breaks", 2, u_dev_model.n_break);
        check("no stray byte", 0, u_dev_model.rx_q.size());
        // far side that holds the line low for 600 cycles, past the 500-cycle enable wait: host must give up
        u_dev_model.enabled = 1'b0;
        u_dev_model.hold = 600;
        pulse(en_req);
        wait_rx(n);
        check("enable timeout", 1, timeout);
        check("enable wait span", 1, n >= 500);
        repeat (100) @(negedge clk);
        check("re-enabled", 1, u_dev_model.enabled);
        // reset in the middle of a receive wait
        pulse(expect_rx);
        repeat (4) @(negedge clk);
        rstn = 1'b0;
        @(negedge clk);
        check("mid reset busy", 0, busy);
        check("mid reset oe", 0, host_oe);
        rstn = 1'b1;
        send_data = 8'h3c;
        send_sync = 1'b0;
        pulse(send_valid);
        wait_idle();
        check("after reset", 8'h3c, u_dev_model.rx_q.pop_front());
        check("after reset faults", 0, u_dev_model.n_bad);
        end_of_test();
    end
endmodule
